// ### dpts_ctrl.sv
/*
  controller end: turns user accesses into packet sequences per bank state.
  assumes one access at a time; user holds acc_* until acc_ready pulse, acc_wdata one cycle past it.
*/
module dpts_ctrl (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  dpts_link_if.ctrl                          link,
  input  wire logic                          acc_valid,
  input  wire logic                          acc_write,
  input  wire logic                          acc_close,
  input  wire logic [1:0]                    acc_len,
  input  wire logic [dpts_pkg::BANK_W-1:0]   acc_bank,
  input  wire logic [dpts_pkg::ROW_W-1:0]    acc_row,
  input  wire logic [dpts_pkg::COL_W-1:0]    acc_col,
  input  wire logic [dpts_pkg::DATA_W-1:0]   acc_wdata,
  output logic                               acc_ready,
  output logic                               rd_valid,
  output logic [dpts_pkg::DATA_W-1:0]        rd_data
);

  // ------------------------------------------------------------
  // timing counts
  // ------------------------------------------------------------
  localparam int CW = dpts_pkg::CNT_W;
  localparam int WD = dpts_pkg::WRITE_DATA_DELAY_CYC;
  localparam logic [CW-1:0] T_CC  = CW'(dpts_pkg::COLUMN_CYCLE_TIME_CYC);
  localparam logic [CW-1:0] T_RP  = CW'(dpts_pkg::PRECHARGE_TIME_CYC);
  localparam logic [CW-1:0] T_RCW = CW'(dpts_pkg::ROW_TO_COL_WR_CYC);
  localparam logic [CW-1:0] T_RCR = CW'(dpts_pkg::ROW_TO_COL_RD_CYC);
  localparam logic [CW-1:0] T_WRP = CW'(dpts_pkg::WRITE_TO_PRE_CYC);
  localparam logic [CW-1:0] T_RDP = CW'(dpts_pkg::READ_TO_PRE_CYC);
  localparam logic [CW-1:0] T_RAS = CW'(dpts_pkg::MIN_ROW_ACTIVE_CYC);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_ACT,
    ST_COL,
    ST_CLOSE,
    ST_DONE
  } dpts_st_t;

  typedef struct packed {
    dpts_st_t                                   st;
    logic [dpts_pkg::NBANK-1:0]                 open;
    logic [dpts_pkg::NBANK-1:0][dpts_pkg::ROW_W-1:0] row;
    logic [CW-1:0]                              wait_c;
    logic [CW-1:0]                              ras_c;
    logic [1:0]                                 left;
    logic [dpts_pkg::COL_W-1:0]                 col;
    logic                                       rq_v;
    dpts_pkg::dpts_cmd_t                        rq_cmd;
    logic [dpts_pkg::BANK_W-1:0]                rq_bank;
    logic [dpts_pkg::ROW_W-1:0]                 rq_row;
    logic [dpts_pkg::COL_W-1:0]                 rq_col;
    logic [WD-1:0]                              wd_v;
    logic                                       wv;
    logic [dpts_pkg::DATA_W-1:0]                wd;
    logic                                       rdy;
    logic                                       rv;
    logic [dpts_pkg::DATA_W-1:0]                rd;
  } dpts_ctl_st_t;

  dpts_ctl_st_t s_q, s_d;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // counters reload a cycle late, so every gap gets one slack cycle
  always_comb
  begin
    s_d = s_q;
    s_d.rq_v = 1'b0;
    s_d.rq_cmd = dpts_pkg::DPTS_CMD_NOP;
    s_d.rdy = 1'b0;
    s_d.rv = link.rdata_valid;
    s_d.rd = link.rdata;
    // write data presented delay after column write
    s_d.wd_v = {s_q.wd_v[WD-2:0], 1'b0};
    s_d.wv = s_q.wd_v[WD-1];
    s_d.wd = s_q.wd_v[WD-1] ? acc_wdata : '0;
    if (s_q.wait_c != '0)
      s_d.wait_c = s_q.wait_c - 1'b1;
    if (s_q.ras_c != '0)
      s_d.ras_c = s_q.ras_c - 1'b1;
    s_d.rq_bank = acc_bank;
    s_d.rq_row = acc_row;
    s_d.rq_col = s_q.col;
    unique case (s_q.st)
      ST_IDLE:
        // spacing counter still running: next access waits
        if (acc_valid && s_q.wait_c == '0)
        begin
          s_d.col = acc_col;
          s_d.left = acc_len;
          if (s_q.open[acc_bank] && s_q.row[acc_bank] == acc_row)
            s_d.st = ST_COL;
          else if (s_q.open[acc_bank])
            s_d.st = ST_PRE;
          else
            s_d.st = ST_ACT;
        end
      ST_PRE:
        if (s_q.ras_c == '0 && s_q.wait_c == '0)
        begin
          s_d.rq_v = 1'b1;
          s_d.rq_cmd = dpts_pkg::DPTS_CMD_PRE;
          s_d.open[acc_bank] = 1'b0;
          s_d.wait_c = T_RP;
          s_d.st = ST_ACT;
        end
      ST_ACT:
        if (s_q.wait_c == '0)
        begin
          s_d.rq_v = 1'b1;
          s_d.rq_cmd = dpts_pkg::DPTS_CMD_ACT;
          s_d.open[acc_bank] = 1'b1;
          s_d.row[acc_bank] = acc_row;
          if (acc_write)
            s_d.wait_c = T_RCW;
          else
            s_d.wait_c = T_RCR;
          s_d.ras_c = T_RAS;
          s_d.st = ST_COL;
        end
      ST_COL:
        if (s_q.wait_c == '0)
        begin
          s_d.rq_v = 1'b1;
          if (acc_write)
            s_d.rq_cmd = dpts_pkg::DPTS_CMD_WR;
          else
            s_d.rq_cmd = dpts_pkg::DPTS_CMD_RD;
          s_d.wd_v[0] = acc_write;
          s_d.col = s_q.col + 1'b1;
          s_d.wait_c = T_CC;
          if (s_q.left == 2'h0)
          begin
            if (acc_write)
              s_d.wait_c = T_WRP;
            else
              s_d.wait_c = T_RDP;
            s_d.st = acc_close ? ST_CLOSE : ST_DONE;
          end
          else
            s_d.left = s_q.left - 1'b1;
        end
      ST_CLOSE:
        // max of ras and write or read sum
        if (s_q.wait_c == '0 && s_q.ras_c == '0)
        begin
          s_d.rq_v = 1'b1;
          s_d.rq_cmd = dpts_pkg::DPTS_CMD_PRE;
          s_d.open[acc_bank] = 1'b0;
          s_d.wait_c = T_RP;
          s_d.st = ST_DONE;
        end
      ST_DONE:
      begin
        s_d.rdy = 1'b1;
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign link.req_valid   = s_q.rq_v;
  assign link.req_cmd     = s_q.rq_cmd;
  assign link.req_bank    = s_q.rq_bank;
  assign link.req_row     = s_q.rq_row;
  assign link.req_col     = s_q.rq_col;
  assign link.wdata_valid = s_q.wv;
  assign link.wdata       = s_q.wd;
  assign acc_ready        = s_q.rdy;
  assign rd_valid         = s_q.rv;
  assign rd_data          = s_q.rd;
endmodule // dpts_ctrl

// ### dpts_pkg.sv
/*
  package of the page transaction sequencer: link commands, timing counts in request cycles.
  assumes both ends run on one request clock, sys_clk at 25 MHz.
*/
// Operation
// - packet count follows bank state and address
// - controller compares row for hit/miss
// - page-hit write uses column writes only
// - page-hit read uses column reads only
// - write data follows column write by delay
// - read data returned fixed delay after read
// - column packets spaced by column cycle time
// - page-miss: precharge, wait, then activate
// - page-empty: activate, wait row-to-column delay
// - controller remembers banks left open
// - precharge waits write-to-precharge after write
// - precharge waits read-to-precharge after read
// - page policy decides close or leave open
// - precharge never before min row active time
// - read act-to-pre is max of both limits
// - write act-to-pre respects write delay sum
// - precharge to activate keeps precharge time
// - same-kind column packets keep column cycle
package dpts_pkg;
  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int BANK_W = 3;
  localparam int ROW_W  = 12;
  localparam int COL_W  = 6;
  localparam int DATA_W = 16;
  localparam int NBANK  = 1 << BANK_W;

  typedef enum logic [2:0] {
    DPTS_CMD_NOP,
    DPTS_CMD_ACT,
    DPTS_CMD_PRE,
    DPTS_CMD_WR,
    DPTS_CMD_RD
  } dpts_cmd_t;

  // ------------------------------------------------------------
  // timing, ns and derived cycles
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int WRITE_DATA_DELAY_NS          = 120;
  localparam int READ_DATA_DELAY_NS           = 240;
  localparam int COLUMN_CYCLE_TIME_NS         = 80;
  localparam int PRECHARGE_TIME_NS            = 240;
  localparam int ROW_TO_COLUMN_WRITE_DELAY_NS = 40;
  localparam int ROW_TO_COLUMN_READ_DELAY_NS  = 200;
  localparam int WRITE_TO_PRECHARGE_TIME_NS   = 440;
  localparam int READ_TO_PRECHARGE_TIME_NS    = 120;
  localparam int MIN_ROW_ACTIVE_TIME_NS       = 360;

  function automatic int cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WRITE_DATA_DELAY_CYC   = cyc(WRITE_DATA_DELAY_NS);
  localparam int READ_DATA_DELAY_CYC    = cyc(READ_DATA_DELAY_NS);
  localparam int COLUMN_CYCLE_TIME_CYC  = cyc(COLUMN_CYCLE_TIME_NS);
  localparam int PRECHARGE_TIME_CYC     = cyc(PRECHARGE_TIME_NS);
  localparam int ROW_TO_COL_WR_CYC      = cyc(ROW_TO_COLUMN_WRITE_DELAY_NS);
  localparam int ROW_TO_COL_RD_CYC      = cyc(ROW_TO_COLUMN_READ_DELAY_NS);
  localparam int WRITE_TO_PRE_CYC       = cyc(WRITE_TO_PRECHARGE_TIME_NS);
  localparam int READ_TO_PRE_CYC        = cyc(READ_TO_PRECHARGE_TIME_NS);
  localparam int MIN_ROW_ACTIVE_CYC     = cyc(MIN_ROW_ACTIVE_TIME_NS);
  localparam int CNT_W = 6;
endpackage : dpts_pkg

// ### dpts_link_if.sv
/*
  request/data link between controller and device.
  assumes one clock; the testbench binds both ends.
*/
interface dpts_link_if;
  logic                          req_valid;
  dpts_pkg::dpts_cmd_t           req_cmd;
  logic [dpts_pkg::BANK_W-1:0]   req_bank;
  logic [dpts_pkg::ROW_W-1:0]    req_row;
  logic [dpts_pkg::COL_W-1:0]    req_col;
  logic                          wdata_valid;
  logic [dpts_pkg::DATA_W-1:0]   wdata;
  logic                          rdata_valid;
  logic [dpts_pkg::DATA_W-1:0]   rdata;

  modport device (
    input  req_valid, req_cmd, req_bank, req_row, req_col, wdata_valid, wdata,
    output rdata_valid, rdata
  );
  modport ctrl (
    output req_valid, req_cmd, req_bank, req_row, req_col, wdata_valid, wdata,
    input  rdata_valid, rdata
  );
endinterface : dpts_link_if

// ### dpts_device.sv
/*
  device end: banked array with sense rows, timed data packets.
  assumes the controller keeps every spacing rule; no check here.
*/
module dpts_device (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  dpts_link_if.device                      link,
  output logic [dpts_pkg::NBANK-1:0]       bank_open,
  output logic                             wr_done
);
  localparam int WD = dpts_pkg::WRITE_DATA_DELAY_CYC;
  localparam int RD = dpts_pkg::READ_DATA_DELAY_CYC;
  localparam int AW = dpts_pkg::BANK_W + dpts_pkg::COL_W;

  // open row array, only modelled as the sensed row's columns
  logic [dpts_pkg::DATA_W-1:0] mem_q [0:(1<<AW)-1];

  typedef struct packed {
    logic [dpts_pkg::NBANK-1:0]  open;
    logic [WD-1:0]               wpend;
    logic [WD-1:0][AW-1:0]       waddr;
    logic [RD-2:0]               rpend;
    logic [RD-2:0][AW-1:0]       raddr;
    logic                        rvalid;
    logic [dpts_pkg::DATA_W-1:0] rdata;
    logic                        wdone;
  } dpts_dev_st_t;

  dpts_dev_st_t s_q, s_d;
  logic [AW-1:0] link_addr;

  assign link_addr = {link.req_bank, link.req_col};

  always_comb
  begin
    s_d = s_q;
    s_d.wdone = 1'b0;
    if (link.req_valid && link.req_cmd == dpts_pkg::DPTS_CMD_ACT)
      s_d.open[link.req_bank] = 1'b1;
    if (link.req_valid && link.req_cmd == dpts_pkg::DPTS_CMD_PRE)
      s_d.open[link.req_bank] = 1'b0;
    s_d.wpend = {s_q.wpend[WD-2:0],
                 link.req_valid && link.req_cmd == dpts_pkg::DPTS_CMD_WR};
    s_d.waddr = {s_q.waddr[WD-2:0], link_addr};
    if (s_q.wpend[WD-1])
      s_d.wdone = 1'b1;
    // read delay pipe
    // output flop is the last stage, so the pipe is one short
    s_d.rpend = {s_q.rpend[RD-3:0],
                 link.req_valid && link.req_cmd == dpts_pkg::DPTS_CMD_RD};
    s_d.raddr = {s_q.raddr[RD-3:0], link_addr};
    s_d.rvalid = s_q.rpend[RD-2];
    s_d.rdata  = s_q.rpend[RD-2] ? mem_q[s_q.raddr[RD-2]] : '0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (s_q.wpend[WD-1] && link.wdata_valid)
      mem_q[s_q.waddr[WD-1]] <= link.wdata;
  end

  assign link.rdata_valid = s_q.rvalid;
  assign link.rdata       = s_q.rdata;
  assign bank_open        = s_q.open;
  assign wr_done          = s_q.wdone;
endmodule // dpts_device

// ### dpts_sva.sv
/*
  assertions on the request/data link between controller and device.
  assumes one clock; instantiated beside the link interface.
*/
module dpts_sva (
  input wire logic                        sys_clk,
  input wire logic                        rst_n,
  input wire logic                        req_valid,
  input wire dpts_pkg::dpts_cmd_t         req_cmd,
  input wire logic [dpts_pkg::BANK_W-1:0] req_bank,
  input wire logic                        wdata_valid,
  input wire logic                        rdata_valid
);
  // ------------------------------------------------------------
  // per-bank packet ages
  // ------------------------------------------------------------
  localparam int WD   = dpts_pkg::WRITE_DATA_DELAY_CYC;
  localparam int RDL  = dpts_pkg::READ_DATA_DELAY_CYC;
  localparam int RP   = dpts_pkg::PRECHARGE_TIME_CYC;
  localparam int RAS  = dpts_pkg::MIN_ROW_ACTIVE_CYC;
  localparam int RCDW = dpts_pkg::ROW_TO_COL_WR_CYC;
  localparam int RCDR = dpts_pkg::ROW_TO_COL_RD_CYC;
  localparam int WRP  = dpts_pkg::WRITE_TO_PRE_CYC;
  localparam int RDP  = dpts_pkg::READ_TO_PRE_CYC;
  logic       act_p, pre_p, wr_p, rd_p;
  logic [7:0] act_a [8];
  logic [7:0] pre_a [8];
  logic [7:0] wr_a  [8];
  logic [7:0] rd_a  [8];
  logic [7:0] open_q;
  assign act_p = req_valid && req_cmd == dpts_pkg::DPTS_CMD_ACT;
  assign pre_p = req_valid && req_cmd == dpts_pkg::DPTS_CMD_PRE;
  assign wr_p  = req_valid && req_cmd == dpts_pkg::DPTS_CMD_WR;
  assign rd_p  = req_valid && req_cmd == dpts_pkg::DPTS_CMD_RD;
  function automatic logic [7:0] age(input logic hit, input logic [7:0] a);
    return hit ? 8'h01 : (a == 8'hff) ? a : a + 8'h01;
  endfunction
  // ages saturate, so a bank idle for long never looks recent
  always_ff @(posedge sys_clk)
  begin
    for (int b = 0; b < 8; b++)
    begin
      act_a[b]  <= !rst_n ? 8'hff : age(act_p && req_bank == 3'(b), act_a[b]);
      pre_a[b]  <= !rst_n ? 8'hff : age(pre_p && req_bank == 3'(b), pre_a[b]);
      wr_a[b]   <= !rst_n ? 8'hff : age(wr_p && req_bank == 3'(b), wr_a[b]);
      rd_a[b]   <= !rst_n ? 8'hff : age(rd_p && req_bank == 3'(b), rd_a[b]);
      open_q[b] <= !rst_n ? 1'b0 : ((act_p || pre_p) && req_bank == 3'(b)) ? act_p : open_q[b];
    end
  end
  // ------------------------------------------------------------
  // link timing
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_wr_data; wr_p |-> ##WD wdata_valid; endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not at fixed delay");
  property p_wr_src; wdata_valid |-> $past(wr_p, WD); endproperty
  a_wr_src: assert property (p_wr_src) else $error("write data without column write");
  property p_rd_data; rd_p |-> ##RDL rdata_valid; endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data not at fixed delay");
  property p_rd_src; rdata_valid |-> $past(rd_p, RDL); endproperty
  a_rd_src: assert property (p_rd_src) else $error("read data without column read");
  property p_col_gap; (wr_p |=> !wr_p) and (rd_p |=> !rd_p); endproperty
  a_col_gap: assert property (p_col_gap) else $error("column packets too close");
  property p_rp; act_p |-> pre_a[req_bank] >= RP; endproperty
  a_rp: assert property (p_rp) else $error("activate too soon after precharge");
  property p_ras; pre_p |-> act_a[req_bank] >= RAS; endproperty
  a_ras: assert property (p_ras) else $error("precharge too soon after activate");
  property p_rcd; (wr_p |-> act_a[req_bank] >= RCDW) and (rd_p |-> act_a[req_bank] >= RCDR);
  endproperty
  a_rcd: assert property (p_rcd) else $error("column too soon after activate");
  property p_col_pre; pre_p |-> wr_a[req_bank] >= WRP && rd_a[req_bank] >= RDP; endproperty
  a_col_pre: assert property (p_col_pre) else $error("precharge too soon after column");
  property p_closed; act_p |-> !open_q[req_bank]; endproperty
  a_closed: assert property (p_closed) else $error("activate to an open bank");
  property p_open; (wr_p || rd_p) |-> open_q[req_bank]; endproperty
  a_open: assert property (p_open) else $error("column packet to a closed bank");
endmodule // dpts_sva

// ### dram_page_transaction_sequencer_test.sv
/*
  testbench: controller and device joined by the link, driven by user accesses.
  assumes nothing outside; makes clock and synchronous reset.
*/
module dram_page_transaction_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                        sys_clk, rst_n, acc_valid, acc_write, acc_close;
  logic [1:0]                  acc_len;
  logic [dpts_pkg::BANK_W-1:0] acc_bank;
  logic [dpts_pkg::ROW_W-1:0]  acc_row;
  logic [dpts_pkg::COL_W-1:0]  acc_col;
  logic [dpts_pkg::DATA_W-1:0] acc_wdata, rd_data;
  logic                        acc_ready, rd_valid, wr_done;
  logic [dpts_pkg::NBANK-1:0]  bank_open;
  logic [15:0]                 mem [512];
  logic [15:0]                 rq [$];
  int                          err_count, cmp_count, n_act, n_pre, n_col, n_wd;
  // ------------------------------------------------------------
  // ends and checker
  // ------------------------------------------------------------
  always #20 sys_clk = ~sys_clk;
  dpts_link_if dpts_link_if_i ();
  dpts_device dpts_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(dpts_link_if_i.device),
    .bank_open(bank_open), .wr_done(wr_done));
  dpts_ctrl dpts_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(dpts_link_if_i.ctrl),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_close(acc_close), .acc_len(acc_len),
    .acc_bank(acc_bank), .acc_row(acc_row), .acc_col(acc_col), .acc_wdata(acc_wdata),
    .acc_ready(acc_ready), .rd_valid(rd_valid), .rd_data(rd_data));
  dpts_sva dpts_sva_i (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(dpts_link_if_i.req_valid),
    .req_cmd(dpts_link_if_i.req_cmd), .req_bank(dpts_link_if_i.req_bank),
    .wdata_valid(dpts_link_if_i.wdata_valid), .rdata_valid(dpts_link_if_i.rdata_valid));
  // ------------------------------------------------------------
  // compare, verdict, link monitor
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    if (dpts_link_if_i.req_valid === 1'b1)
    begin
      n_act += (dpts_link_if_i.req_cmd === dpts_pkg::DPTS_CMD_ACT);
      n_pre += (dpts_link_if_i.req_cmd === dpts_pkg::DPTS_CMD_PRE);
      n_col += (dpts_link_if_i.req_cmd inside {dpts_pkg::DPTS_CMD_WR, dpts_pkg::DPTS_CMD_RD});
    end
    if (wr_done === 1'b1)
      n_wd++;
    if (rd_valid === 1'b1)
      rq.push_back(rd_data);
    if (dpts_link_if_i.wdata_valid === 1'b1)
      chk(dpts_link_if_i.wdata, acc_wdata);
  end
  // ------------------------------------------------------------
  // one access, then packet counts and data
  // ------------------------------------------------------------
  task automatic access(input logic w, input logic c, input logic [1:0] n, input logic [2:0] b,
    input logic [11:0] r, input logic [5:0] col, input logic [15:0] d, input int ea, input int ep);
    int k;
    @(posedge sys_clk);
    n_act = 0; n_pre = 0; n_col = 0; n_wd = 0; rq.delete();
    acc_valid <= 1'b1; acc_write <= w; acc_close <= c; acc_len <= n;
    acc_bank <= b; acc_row <= r; acc_col <= col; acc_wdata <= d;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (acc_ready !== 1'b1 && k < 300);
    acc_valid <= 1'b0;
    // data may still trail the ready pulse
    while ((w ? n_wd : rq.size()) < n + 1 && k < 340)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 300)
    begin
      err_count++;
      test_done();
    end
    chk(n_act, ea);
    chk(n_pre, ep);
    chk(n_col, n + 1);
    chk(bank_open[b], !c);
    for (int i = 0; i <= n; i++)
      if (w)
        mem[{b, col + 6'(i)}] = d;
      else
        chk(rq[i], mem[{b, col + 6'(i)}]);
    repeat (2) @(posedge sys_clk);
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0; rst_n = 1'b0; acc_valid = 1'b0; acc_write = 1'b0; acc_close = 1'b0;
    acc_len = 2'h0; acc_bank = 3'h0; acc_row = 12'h000; acc_col = 6'h00; acc_wdata = 16'h0000;
    err_count = 0; cmp_count = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    access(1'b1, 1'b0, 2'h1, 3'h0, 12'h005, 6'h00, 16'ha5a5, 1, 0);
    access(1'b0, 1'b0, 2'h1, 3'h0, 12'h005, 6'h00, 16'h0000, 0, 0);
    access(1'b1, 1'b1, 2'h3, 3'h0, 12'h009, 6'h04, 16'h3c3c, 1, 2);
    access(1'b0, 1'b1, 2'h3, 3'h0, 12'h009, 6'h04, 16'h0000, 1, 1);
    access(1'b1, 1'b1, 2'h0, 3'h7, 12'hfff, 6'h3f, 16'hffff, 1, 1);
    access(1'b0, 1'b0, 2'h0, 3'h7, 12'hfff, 6'h3f, 16'h0000, 1, 0);
    access(1'b1, 1'b0, 2'h1, 3'h7, 12'hfff, 6'h3e, 16'h1234, 0, 0);
    // reset in mid-run closes every bank
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(bank_open, 8'h00);
    rst_n <= 1'b1;
    access(1'b1, 1'b1, 2'h1, 3'h7, 12'h001, 6'h3e, 16'h5a5a, 1, 1);
    test_done();
  end
endmodule // dram_page_transaction_sequencer_test
